// ### design/wwdt_defs.svh
`ifndef WWDT_DEFS_SVH
`define WWDT_DEFS_SVH

// Clock rates and the divider that makes the low-speed oscillator tick.
`define WWDT_CLK_HZ        100000000
`define WWDT_LSOSC_HZ      264000
`define WWDT_LSOSC_DIV     (`WWDT_CLK_HZ / `WWDT_LSOSC_HZ)

// Option byte field positions.
`define WWDT_OPT_STBY_BIT  0
`define WWDT_OPT_SEL_LSB   1
`define WWDT_OPT_SEL_MSB   3

// Restart key and counter geometry.
`define WWDT_KEY           8'hAC
`define WWDT_CNT_W         21
`define WWDT_CNT_RESET     21'h000000

// Overflow exponents in low-speed ticks for selection codes 0 to 7.
`define WWDT_EXP_SEL0      10
`define WWDT_EXP_SEL1      11
`define WWDT_EXP_SEL2      12
`define WWDT_EXP_SEL3      13
`define WWDT_EXP_SEL4      15
`define WWDT_EXP_SEL5      17
`define WWDT_EXP_SEL6      18
`define WWDT_EXP_SEL7      20

`endif

// ### design/wwdt_pkg.sv
package wwdt_pkg;

    typedef enum logic [1:0] {
        WWDT_LOAD  = 2'b00,
        WWDT_RUN   = 2'b01,
        WWDT_SLEEP = 2'b11,
        WWDT_FIRE  = 2'b10
    } wwdt_state_e;

    typedef struct packed {
        logic       standby_run_select;
        logic [2:0] overflow_period_sel;
    } wwdt_option_s;

    typedef struct packed {
        logic       strobe;
        logic [7:0] data;
    } wwdt_key_write_s;

    typedef struct packed {
        logic halt;
        logic stop;
    } wwdt_power_s;

endpackage : wwdt_pkg

// ### design/wwdt_top.sv
`include "wwdt_defs.svh"

// Notes on behaviour
// - Standby-run bit 0 stops counting in HALT and STOP; bit 1 keeps counting.
// - With standby-run 0, leaving HALT or STOP clears the count, then counting resumes.
// - Counting never pauses for flash self-programming or EEPROM emulation.
// - Overflow period comes from option byte bits 3 to 1, not a register.
// - Counter reaching the selected period raises the internal reset.
// - Key write inside the open window clears the count and restarts from zero.
// - Codes 0 to 7 give 2^10,11,12,13,15,17,18,20 low-speed ticks.
// - After STOP release the count runs through oscillator wait and may reset.
// - The counter is clocked by the low-speed oscillator rate, 264 kHz.
module wwdt_top #(
    parameter int unsigned LSOSC_DIV   = `WWDT_LSOSC_DIV,
    parameter bit          WINDOW_HALF = 1'b0
) (
    // Clock and reset.
    input  wire logic                     ref_clk_in,
    input  wire logic                     rst_n_in,
    // Option byte, sampled after reset.
    input  wire logic [7:0]               option_byte_in,
    // CPU key write to the watchdog enable register.
    input  wire wwdt_pkg::wwdt_key_write_s key_write_in,
    // Standby modes.
    input  wire wwdt_pkg::wwdt_power_s    power_in,
    // Results.
    output logic                          wdt_reset_out,
    output logic                          running_out
);
    import wwdt_pkg::*;

    localparam logic [15:0] DIV_LAST = 16'(LSOSC_DIV - 1);

    function automatic logic [`WWDT_CNT_W-1:0] ovf_limit(input logic [2:0] sel);
        logic [`WWDT_CNT_W-1:0] one;
        one = 21'h000001;
        case (sel)
            3'h0:    ovf_limit = one << `WWDT_EXP_SEL0;
            3'h1:    ovf_limit = one << `WWDT_EXP_SEL1;
            3'h2:    ovf_limit = one << `WWDT_EXP_SEL2;
            3'h3:    ovf_limit = one << `WWDT_EXP_SEL3;
            3'h4:    ovf_limit = one << `WWDT_EXP_SEL4;
            3'h5:    ovf_limit = one << `WWDT_EXP_SEL5;
            3'h6:    ovf_limit = one << `WWDT_EXP_SEL6;
            default: ovf_limit = one << `WWDT_EXP_SEL7;
        endcase
    endfunction : ovf_limit

    // Reset release through two flip-flops.
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Divider producing one enable pulse per low-speed oscillator period.
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic        tick_reg;
    logic        tick_next;

    always_comb begin
        if (div_reg >= DIV_LAST) begin
            div_next  = 16'h0000;
            tick_next = 1'b1;
        end else begin
            div_next  = div_reg + 16'h0001;
            tick_next = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    // Watchdog state, counter and latched options.
    wwdt_state_e            state_reg;
    wwdt_state_e            state_next;
    logic [`WWDT_CNT_W-1:0] cnt_reg;
    logic [`WWDT_CNT_W-1:0] cnt_next;
    wwdt_option_s           opt_reg;
    wwdt_option_s           opt_next;
    logic                   reset_reg;
    logic                   reset_next;
    logic                   running_reg;
    logic                   running_next;

    logic [`WWDT_CNT_W-1:0] limit;
    logic [`WWDT_CNT_W-1:0] cnt_plus;
    logic                   in_standby;
    logic                   window_open;
    logic                   key_hit;
    logic                   ovf;

    always_comb begin
        limit       = ovf_limit(opt_reg.overflow_period_sel);
        cnt_plus    = cnt_reg + 21'h000001;
        in_standby  = power_in.halt | power_in.stop;
        window_open = !WINDOW_HALF || (cnt_reg >= (limit >> 1));
        key_hit     = key_write_in.strobe && (key_write_in.data == `WWDT_KEY) && window_open;
        ovf         = tick_reg && (cnt_plus == limit);
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        opt_next    = opt_reg;
        reset_next  = 1'b0;
        case (state_reg)
            WWDT_LOAD: begin
                opt_next.standby_run_select  =
                    option_byte_in[`WWDT_OPT_STBY_BIT];
                opt_next.overflow_period_sel =
                    option_byte_in[`WWDT_OPT_SEL_MSB:`WWDT_OPT_SEL_LSB];
                cnt_next   = `WWDT_CNT_RESET;
                state_next = WWDT_RUN;
            end
            WWDT_RUN: begin
                if (in_standby && !opt_reg.standby_run_select) begin
                    state_next = WWDT_SLEEP;
                end else if (key_hit) begin
                    cnt_next = `WWDT_CNT_RESET;
                end else if (ovf) begin
                    cnt_next   = `WWDT_CNT_RESET;
                    reset_next = 1'b1;
                    state_next = WWDT_FIRE;
                end else if (tick_reg) begin
                    cnt_next = cnt_plus;
                end
            end
            WWDT_SLEEP: begin
                if (!in_standby) begin
                    cnt_next   = `WWDT_CNT_RESET;
                    state_next = WWDT_RUN;
                end
            end
            default: begin
                state_next = WWDT_LOAD;
            end
        endcase
        running_next = (state_next == WWDT_RUN);
    end

    always_ff @(posedge ref_clk_in or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg   <= WWDT_LOAD;
            cnt_reg     <= `WWDT_CNT_RESET;
            opt_reg     <= '0;
            reset_reg   <= 1'b0;
            running_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            opt_reg     <= opt_next;
            reset_reg   <= reset_next;
            running_reg <= running_next;
        end
    end

    assign wdt_reset_out = reset_reg;
    assign running_out   = running_reg;

    // Checks.
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_sync_reg);

    property p_sleep_holds;
        (state_reg == WWDT_SLEEP) && in_standby |=> $stable(cnt_reg) && !wdt_reset_out;
    endproperty
    a_sleep_holds: assert property (p_sleep_holds) else $error("count moved in standby");

    property p_standby_runs;
        (state_reg == WWDT_RUN) && in_standby && opt_reg.standby_run_select
            && tick_reg && !key_hit && !ovf |=> cnt_reg == $past(cnt_reg) + 21'h000001;
    endproperty
    a_standby_runs: assert property (p_standby_runs) else $error("standby run stalled");

    property p_release_clears;
        (state_reg == WWDT_SLEEP) && !in_standby |=> (state_reg == WWDT_RUN) && cnt_reg == '0;
    endproperty
    a_release_clears: assert property (p_release_clears) else $error("release not cleared");

    property p_free_count;
        (state_reg == WWDT_RUN) && !in_standby && tick_reg && !key_hit && !ovf
            |=> cnt_reg == $past(cnt_reg) + 21'h000001;
    endproperty
    a_free_count: assert property (p_free_count) else $error("count did not advance");

    // Judged on the first RUN cycle so the reset-release edge, still in LOAD, is not tried.
    property p_option_latch;
        (state_reg == WWDT_RUN) && ($past(state_reg) == WWDT_LOAD)
            |-> opt_reg.overflow_period_sel == $past(option_byte_in[3:1])
            && opt_reg.standby_run_select == $past(option_byte_in[0]);
    endproperty
    a_option_latch: assert property (p_option_latch) else $error("option not latched");

    property p_overflow_reset;
        (state_reg == WWDT_RUN) && !(in_standby && !opt_reg.standby_run_select)
            && !key_hit && ovf |=> wdt_reset_out ##1 !wdt_reset_out;
    endproperty
    a_overflow_reset: assert property (p_overflow_reset) else $error("overflow missed");

    property p_key_restart;
        (state_reg == WWDT_RUN) && key_hit && !in_standby |=> cnt_reg == '0 && !wdt_reset_out;
    endproperty
    a_key_restart: assert property (p_key_restart) else $error("key did not restart");

    property p_limit_exact;
        wdt_reset_out |-> $past(cnt_reg) == ovf_limit(opt_reg.overflow_period_sel) - 21'h000001;
    endproperty
    a_limit_exact: assert property (p_limit_exact) else $error("wrong overflow count");

    property p_tick_spacing;
        tick_reg |=> !tick_reg;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

    property p_self_restart;
        wdt_reset_out |-> (state_reg == WWDT_FIRE) ##1 (state_reg == WWDT_LOAD)
            ##1 (state_reg == WWDT_RUN) && cnt_reg == '0;
    endproperty
    a_self_restart: assert property (p_self_restart) else $error("no restart after reset");

    c_overflow: cover property (wdt_reset_out);
    c_key:      cover property ((state_reg == WWDT_RUN) && key_hit && cnt_reg != '0);
    c_release:  cover property ((state_reg == WWDT_SLEEP) ##1 (state_reg == WWDT_RUN));
    c_stby_run: cover property ((state_reg == WWDT_RUN) && in_standby && tick_reg);

endmodule : wwdt_top

// ### tb/windowed_watchdog_timer_test.sv
module windowed_watchdog_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import wwdt_pkg::*;

    localparam int DIV = 2;

    logic            ref_clk_in     = 1'b0;
    logic            rst_n_in       = 1'b0;
    logic [7:0]      option_byte_in = 8'h00;
    wwdt_key_write_s key_write_in   = '0;
    wwdt_power_s     power_in       = '0;
    logic            wdt_reset_out;
    logic            running_out;
    int              n_fail         = 0;
    int              comparisons    = 0;

    wwdt_top #(.LSOSC_DIV(DIV), .WINDOW_HALF(1'b0)) u_wwdt_top (
        .ref_clk_in     (ref_clk_in),
        .rst_n_in       (rst_n_in),
        .option_byte_in (option_byte_in),
        .key_write_in   (key_write_in),
        .power_in       (power_in),
        .wdt_reset_out  (wdt_reset_out),
        .running_out    (running_out)
    );

    always #5 ref_clk_in = ~ref_clk_in;

    task automatic final_report();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask : step

    function automatic int period(input int e);
        return (1 << e) * DIV;
    endfunction : period

    // Counts cycles until the reset pulse shows, giving up after lim cycles.
    task automatic wait_fire(input int lim, output int n);
        n = 0;
        while (wdt_reset_out !== 1'b1 && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_fire

    task automatic near(input int n, input int exp);
        check(32'(n >= exp - DIV - 6 && n <= exp + DIV + 6), 32'h1);
    endtask : near

    task automatic wait_run();
        int n;
        n = 0;
        while (running_out !== 1'b1 && n < 8) begin
            step(1);
            n++;
        end
        check(32'(running_out), 32'h1);
    endtask : wait_run

    task automatic do_reset(input logic [7:0] opt);
        @(posedge ref_clk_in);
        rst_n_in       <= 1'b0;
        option_byte_in <= opt;
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        wait_run();
    endtask : do_reset

    task automatic key(input logic [7:0] d);
        @(posedge ref_clk_in);
        key_write_in <= '{strobe: 1'b1, data: d};
        @(posedge ref_clk_in);
        key_write_in <= '0;
    endtask : key

    // Each selection code gives its own overflow period.
    task automatic t_periods();
        int exps[8] = '{10, 11, 12, 13, 15, 17, 18, 20};
        int n;
        for (int i = 0; i < 8; i++) begin
            do_reset({4'h0, 3'(i), 1'b0});
            check(32'(u_wwdt_top.limit), 32'h1 << exps[i]);
            if (i < 4) begin
                wait_fire(period(exps[i]) + 50, n);
                near(n, period(exps[i]));
                step(1);
                check(32'(wdt_reset_out), 32'h0);
                if (i == 0) begin
                    wait_run();
                    wait_fire(period(exps[0]) + 50, n);
                    near(n, period(exps[0]));
                end
            end else begin
                wait_fire(((i == 4) ? period(13) : period(10)) + 100, n);
                check(32'(wdt_reset_out), 32'h0);
            end
        end
    endtask : t_periods

    // A wrong key is ignored; the right key restarts the count from zero.
    task automatic t_key();
        int n;
        do_reset(8'h00);
        step(1500);
        key(8'h55);
        wait_fire(period(10), n);
        near(n, period(10) - 1501);
        wait_run();
        step(1500);
        key(8'hAC);
        wait_fire(period(10) + 50, n);
        near(n, period(10));
    endtask : t_key

    // Standby stops or keeps the count according to the standby-run bit.
    task automatic t_standby(input logic stby, input logic use_stop);
        int n;
        do_reset({7'h00, stby});
        step(1000);
        @(posedge ref_clk_in);
        power_in <= '{halt: ~use_stop, stop: use_stop};
        wait_fire(3000, n);
        if (stby == 1'b0) begin
            check(32'(wdt_reset_out), 32'h0);
            check(32'(running_out), 32'h0);
            @(posedge ref_clk_in);
            power_in <= '0;
            wait_fire(period(10) + 50, n);
            near(n, period(10));
        end else begin
            near(n + 1000, period(10));
            @(posedge ref_clk_in);
            power_in <= '0;
        end
    endtask : t_standby

    initial begin
        repeat (95000) @(posedge ref_clk_in);
        n_fail++;
        final_report();
    end

    initial begin
        t_periods();
        t_key();
        t_standby(1'b0, 1'b0);
        t_standby(1'b0, 1'b1);
        t_standby(1'b1, 1'b0);
        t_standby(1'b1, 1'b1);
        final_report();
    end
endmodule : windowed_watchdog_timer_test
